// ===== pkg/optld_map.svh
// Offsets, option bit positions, encodings and reset values of the option byte loader.
`ifndef OPTLD_MAP_SVH
`define OPTLD_MAP_SVH

// Flash byte addresses that hold the option bytes.
`define OPTLD_FLASH_AW      16
`define OPTLD_USER_ADDR     16'h0000
`define OPTLD_RSVD_ADDR     16'h0001

// Bit positions inside the user option byte.
`define OPTLD_BIT_FWP       0
`define OPTLD_BIT_RSVD      1
`define OPTLD_BIT_OSC_LO    2
`define OPTLD_BIT_OSC_HI    3
`define OPTLD_BIT_BOD_STOP  4
`define OPTLD_BIT_RD_OPEN   5
`define OPTLD_BIT_WDT_RUN   6
`define OPTLD_BIT_WDT_RST   7

// Erased flash content and the option settings held before the first load.
`define OPTLD_ERASED        8'hFF
`define OPTLD_OPT_RST       7'h7F

// Flash command kinds.
`define OPTLD_CMD_PROGRAM   2'h0
`define OPTLD_CMD_PAGE      2'h1
`define OPTLD_CMD_MASS      2'h2

// Register byte offsets on the AXI4-Lite port.
`define OPTLD_AXI_AW        8
`define OPTLD_REG_STATUS    8'h00
`define OPTLD_REG_CONTROL   8'h04
`define OPTLD_CTRL_SOFT     0

// AXI responses.
`define OPTLD_RESP_OKAY     2'h0
`define OPTLD_RESP_SLVERR   2'h2

`endif

// ===== pkg/optld_pkg.sv
// Types shared by the option byte loader.
package optld_pkg;

	typedef enum logic [1:0] {
		S_IDLE,
		S_ISSUE,
		S_WAIT,
		S_APPLY
	} optld_fsm_type;

	// Oscillator selection: external RC, low, medium or high power crystal.
	typedef enum logic [1:0] {
		OSC_EXT_RC,
		OSC_LOW,
		OSC_MEDIUM,
		OSC_HIGH
	} optld_osc_type;

	// Option settings handed to the watchdog, flash, brown-out and clock logic.
	typedef struct packed {
		logic          wdt_reset_on_timeout;
		logic          wdt_run_at_reset;
		logic          read_protect;
		logic          brown_out_detector_in_stop;
		optld_osc_type osc_mode;
		logic          flash_write_protect_off;
	} optld_opt_type;

	// A flash programming or erase request.
	typedef struct packed {
		logic       valid;
		logic [1:0] kind;
		logic       from_on_chip_debugger;
	} optld_fcmd_type;

endpackage

// ===== design/optld_sync2.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/10ps
module optld_sync2 #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Asynchronous input and synchronised output.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} optld_sync_type;

	optld_sync_type st_q;
	optld_sync_type st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '{s1: RST_VAL, s2: RST_VAL};
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;
endmodule

// ===== design/optld_top.sv
// Option byte loader: fetches the option bytes from flash at every reset and holds them.
// Functional notes
// - Every reset source reloads option bytes from flash.
// - New option values act only after reset.
// - Load finishes before the processor leaves reset.
// - Option registers hidden from software access.
// - Options read from flash bytes 0000H, 0001H.
// - Protect bit zero blocks user writes, erases.
// - Protect bit one permits program and erase.
// - Option selects watchdog interrupt or reset.
// - Option selects watchdog running after reset.
// - Option enables flash read protection.
// - Option keeps brown-out detection in stop.
// - Option selects oscillator mode.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "optld_map.svh"
module optld_top
	import optld_pkg::*;
(
	// Clock and reset.
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [`OPTLD_AXI_AW-1:0]    s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [`OPTLD_AXI_AW-1:0]    s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Reset sources.
	input  wire logic                        sys_reset_req,
	input  wire logic                        ext_reset_n_pin,
	input  wire logic                        stop_recovery_pin,
	// Flash read port.
	output logic                             flash_rd_req,
	output logic [`OPTLD_FLASH_AW-1:0]       flash_addr,
	input  wire logic [7:0]                  flash_rdata,
	input  wire logic                        flash_rvalid,
	// Processor reset hold and loaded options.
	output logic                             cpu_reset_hold,
	output optld_opt_type                    opt_cfg,
	// Flash command gate.
	input  wire optld_fcmd_type              fcmd,
	output logic                             fcmd_grant,
	output logic                             fcmd_deny
);
	typedef struct packed {
		optld_fsm_type                fsm;
		logic                         idx;
		logic [7:0]                   byte0;
		logic [7:0]                   byte1;
		optld_opt_type                opt;
		logic                         cpu_hold;
		logic                         flash_rd;
		logic [`OPTLD_FLASH_AW-1:0]   flash_addr;
		logic                         stop_seen;
		logic [7:0]                   load_cnt;
		logic                         rsvd_bad;
		logic                         bit1_bad;
		logic                         grant;
		logic                         deny;
		logic                         aw_got;
		logic                         w_got;
		logic [`OPTLD_AXI_AW-1:0]     waddr;
		logic                         wsoft;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
	} optld_regs_type;

	localparam optld_regs_type ST_RST = '{
		fsm:      S_ISSUE,
		cpu_hold: 1'b1,
		byte0:    `OPTLD_ERASED,
		byte1:    `OPTLD_ERASED,
		opt:      `OPTLD_OPT_RST,
		default:  '0
	};

	optld_regs_type st_q;
	optld_regs_type st_d;
	logic [1:0]     pins_s;
	logic           aw_hs;
	logic           w_hs;
	logic           ar_hs;
	logic           do_write;
	logic           soft_wr;
	logic           trig;
	logic [`OPTLD_AXI_AW-1:0] wa;
	logic [`OPTLD_AXI_AW-1:0] ra;

	// Bit 1 is the external reset pin, bit 0 the stop-mode recovery pin.
	optld_sync2 #(
		.W       (2),
		.RST_VAL (2'b10)
	) u_pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({ext_reset_n_pin, stop_recovery_pin}),
		.q       (pins_s)
	);

	always_comb begin
		st_d          = st_q;
		st_d.flash_rd = 1'b0;
		st_d.grant    = 1'b0;
		st_d.deny     = 1'b0;
		st_d.stop_seen = pins_s[0];
		aw_hs    = s_axi_awvalid & st_q.awready;
		w_hs     = s_axi_wvalid & st_q.wready;
		ar_hs    = s_axi_arvalid & st_q.arready;
		wa       = aw_hs ? s_axi_awaddr : st_q.waddr;
		ra       = {s_axi_araddr[`OPTLD_AXI_AW-1:2], 2'b00};
		do_write = (st_q.aw_got | aw_hs) & (st_q.w_got | w_hs) & ~st_q.bvalid;
		soft_wr  = 1'b0;

		// Write channel: address and data are taken in either order.
		if (aw_hs) begin
			st_d.waddr  = s_axi_awaddr;
			st_d.aw_got = 1'b1;
		end
		if (w_hs) begin
			st_d.wsoft = s_axi_wdata[`OPTLD_CTRL_SOFT] & s_axi_wstrb[0];
			st_d.w_got = 1'b1;
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		if (do_write) begin
			st_d.aw_got = 1'b0;
			st_d.w_got  = 1'b0;
			st_d.bvalid = 1'b1;
			// The option registers have no address; only status and control exist.
			if ({wa[`OPTLD_AXI_AW-1:2], 2'b00} == `OPTLD_REG_CONTROL) begin
				soft_wr     = w_hs ? s_axi_wdata[`OPTLD_CTRL_SOFT] & s_axi_wstrb[0]
				                   : st_q.wsoft;
				st_d.bresp  = `OPTLD_RESP_OKAY;
			end else if ({wa[`OPTLD_AXI_AW-1:2], 2'b00} == `OPTLD_REG_STATUS) begin
				st_d.bresp  = `OPTLD_RESP_OKAY;
			end else begin
				st_d.bresp  = `OPTLD_RESP_SLVERR;
			end
		end
		st_d.awready = ~st_d.aw_got & ~st_d.bvalid;
		st_d.wready  = ~st_d.w_got & ~st_d.bvalid;

		// Read channel.
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (ar_hs) begin
			st_d.rvalid = 1'b1;
			st_d.rresp  = `OPTLD_RESP_OKAY;
			st_d.rdata  = 32'h0000_0000;
			if (ra == `OPTLD_REG_STATUS) begin
				st_d.rdata = {16'h0000, st_q.load_cnt, 4'h0, st_q.bit1_bad, st_q.rsvd_bad,
				              st_q.cpu_hold, st_q.fsm != S_IDLE};
			end else if (ra != `OPTLD_REG_CONTROL) begin
				st_d.rresp = `OPTLD_RESP_SLVERR;
			end
		end
		st_d.arready = ~st_d.rvalid;

		// Loader sequence; the option set changes only in the apply step.
		case (st_q.fsm)
			S_IDLE: begin
				st_d.fsm = S_IDLE;
			end
			S_ISSUE: begin
				st_d.flash_rd   = 1'b1;
				st_d.flash_addr = st_q.idx ? `OPTLD_RSVD_ADDR : `OPTLD_USER_ADDR;
				st_d.fsm        = S_WAIT;
			end
			S_WAIT: begin
				if (flash_rvalid) begin
					if (!st_q.idx) begin
						st_d.byte0 = flash_rdata;
						st_d.idx   = 1'b1;
						st_d.fsm   = S_ISSUE;
					end else begin
						st_d.byte1 = flash_rdata;
						st_d.fsm   = S_APPLY;
					end
				end
			end
			S_APPLY: begin
				st_d.opt.wdt_reset_on_timeout       = st_q.byte0[`OPTLD_BIT_WDT_RST];
				st_d.opt.wdt_run_at_reset           = st_q.byte0[`OPTLD_BIT_WDT_RUN];
				st_d.opt.read_protect               = ~st_q.byte0[`OPTLD_BIT_RD_OPEN];
				st_d.opt.brown_out_detector_in_stop = st_q.byte0[`OPTLD_BIT_BOD_STOP];
				st_d.opt.osc_mode                   = optld_osc_type'(
					st_q.byte0[`OPTLD_BIT_OSC_HI:`OPTLD_BIT_OSC_LO]);
				st_d.opt.flash_write_protect_off    = st_q.byte0[`OPTLD_BIT_FWP];
				// Flag contents that the programming party should not have left.
				st_d.rsvd_bad = st_q.byte1 != `OPTLD_ERASED;
				st_d.bit1_bad = st_q.byte0[`OPTLD_BIT_RSVD];
				st_d.load_cnt = st_q.load_cnt + 8'h01;
				st_d.cpu_hold = 1'b0;
				st_d.fsm      = S_IDLE;
			end
			default: begin
				st_d.fsm = S_IDLE;
			end
		endcase

		// Any reset source restarts the fetch and holds the processor.
		trig = sys_reset_req | ~pins_s[1] | (pins_s[0] & ~st_q.stop_seen) | soft_wr;
		if (trig) begin
			st_d.fsm      = S_ISSUE;
			st_d.idx      = 1'b0;
			st_d.cpu_hold = 1'b1;
		end

		// Write-protect gate; the debugger keeps mass erase.
		if (fcmd.valid) begin
			if (st_q.opt.flash_write_protect_off ||
			    (fcmd.from_on_chip_debugger && fcmd.kind == `OPTLD_CMD_MASS)) begin
				st_d.grant = 1'b1;
			end else begin
				st_d.deny = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign s_axi_awready  = st_q.awready;
	assign s_axi_wready   = st_q.wready;
	assign s_axi_bvalid   = st_q.bvalid;
	assign s_axi_bresp    = st_q.bresp;
	assign s_axi_arready  = st_q.arready;
	assign s_axi_rvalid   = st_q.rvalid;
	assign s_axi_rdata    = st_q.rdata;
	assign s_axi_rresp    = st_q.rresp;
	assign flash_rd_req   = st_q.flash_rd;
	assign flash_addr     = st_q.flash_addr;
	assign cpu_reset_hold = st_q.cpu_hold;
	assign opt_cfg        = st_q.opt;
	assign fcmd_grant     = st_q.grant;
	assign fcmd_deny      = st_q.deny;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_trig_restart;
		trig |=> st_q.fsm == S_ISSUE && st_q.cpu_hold && !st_q.idx;
	endproperty
	a_trig_restart: assert property (p_trig_restart) else $error("reset source lost");

	property p_user_addr;
		st_q.fsm == S_ISSUE && !st_q.idx && !trig |=> flash_rd_req && flash_addr == `OPTLD_USER_ADDR;
	endproperty
	a_user_addr: assert property (p_user_addr) else $error("wrong option address");

	property p_release_after_apply;
		$fell(cpu_reset_hold) |-> $past(st_q.fsm) == S_APPLY;
	endproperty
	a_release_after_apply: assert property (p_release_after_apply)
		else $error("early release");

	property p_opt_stable;
		st_q.fsm != S_APPLY |=> $stable(opt_cfg);
	endproperty
	a_opt_stable: assert property (p_opt_stable) else $error("options changed");

	property p_sw_no_opt;
		s_axi_bvalid && !cpu_reset_hold ##1 !cpu_reset_hold |-> $stable(opt_cfg);
	endproperty
	a_sw_no_opt: assert property (p_sw_no_opt) else $error("write touched options");

	property p_fwp_block;
		fcmd.valid && !opt_cfg.flash_write_protect_off && !fcmd.from_on_chip_debugger
			|=> fcmd_deny && !fcmd_grant;
	endproperty
	a_fwp_block: assert property (p_fwp_block) else $error("protected write granted");

	property p_dbg_mass;
		fcmd.valid && fcmd.from_on_chip_debugger && fcmd.kind == `OPTLD_CMD_MASS |=> fcmd_grant;
	endproperty
	a_dbg_mass: assert property (p_dbg_mass) else $error("debug mass erase denied");

	property p_fwp_allow;
		fcmd.valid && opt_cfg.flash_write_protect_off |=> fcmd_grant && !fcmd_deny;
	endproperty
	a_fwp_allow: assert property (p_fwp_allow) else $error("unprotected write denied");

	property p_wdt_mode;
		st_q.fsm == S_APPLY |=> opt_cfg.wdt_reset_on_timeout == $past(st_q.byte0[7])
			&& opt_cfg.wdt_run_at_reset == $past(st_q.byte0[6]);
	endproperty
	a_wdt_mode: assert property (p_wdt_mode) else $error("watchdog option wrong");

	property p_osc_mode;
		st_q.fsm == S_APPLY |=> opt_cfg.osc_mode == $past(st_q.byte0[3:2])
			&& opt_cfg.read_protect == !$past(st_q.byte0[5]);
	endproperty
	a_osc_mode: assert property (p_osc_mode) else $error("oscillator option wrong");

	c_load_done: cover property ($fell(cpu_reset_hold));
	c_deny: cover property (fcmd_deny);
	c_soft: cover property (soft_wr ##[1:20] $fell(cpu_reset_hold));
endmodule

// ===== tb/optld_flash_model.sv
// Behavioural flash array that answers option byte reads.
`timescale 1ns/10ps
module optld_flash_model (
	// Clock.
	input  wire logic        aclk,
	// Read port.
	input  wire logic        flash_rd_req,
	input  wire logic [15:0] flash_addr,
	output logic      [7:0]  flash_rdata,
	output logic             flash_rvalid,
	// Array content and answer speed.
	input  wire logic [7:0]  user_byte,
	input  wire logic [7:0]  spare_byte,
	input  wire logic        slow
);
	logic       pend;
	logic [1:0] wait_cnt;
	logic [7:0] data;

	initial begin
		pend = 1'b0;
		wait_cnt = 2'h0;
		flash_rdata = 8'h00;
		flash_rvalid = 1'b0;
	end

	// The second byte is what the bench left there, normally erased; elsewhere is junk.
	assign data = (flash_addr == 16'h0001) ? spare_byte :
		(flash_addr == 16'h0000) ? user_byte : ~user_byte;

	// Idle data lines toggle so that a stale byte is never mistaken for an answer.
	always @(posedge aclk) begin
		flash_rvalid <= 1'b0;
		flash_rdata <= ~flash_rdata;
		if (flash_rd_req) begin
			pend <= 1'b1;
			wait_cnt <= slow ? 2'h3 : 2'h0;
		end else if (pend && wait_cnt != 2'h0) begin
			wait_cnt <= wait_cnt - 2'h1;
		end else if (pend) begin
			pend <= 1'b0;
			flash_rvalid <= 1'b1;
			flash_rdata <= data;
		end
	end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the option byte loader.
`timescale 1ns/10ps
`include "optld_map.svh"
module tb_top
	import optld_pkg::*;
;
	logic                     aclk, aresetn, slow;
	logic [`OPTLD_AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]              s_axi_wdata, s_axi_rdata;
	logic [3:0]               s_axi_wstrb;
	logic [1:0]               s_axi_bresp, s_axi_rresp;
	logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                     s_axi_rvalid, s_axi_rready, fcmd_grant, fcmd_deny;
	logic                     sys_reset_req, ext_reset_n_pin, stop_recovery_pin;
	logic                     flash_rd_req, flash_rvalid, cpu_reset_hold;
	logic [15:0]              flash_addr;
	logic [7:0]               flash_rdata, user_byte, spare_byte;
	optld_opt_type            opt_cfg;
	optld_fcmd_type           fcmd;
	int                       err_count, samples_checked;

	optld_top uut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_reset_req, .ext_reset_n_pin,
		.stop_recovery_pin, .flash_rd_req, .flash_addr, .flash_rdata, .flash_rvalid,
		.cpu_reset_hold, .opt_cfg, .fcmd, .fcmd_grant, .fcmd_deny
	);
	optld_flash_model fm (
		.aclk, .flash_rd_req, .flash_addr, .flash_rdata, .flash_rvalid, .user_byte, .spare_byte,
		.slow
	);

	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_opt(input optld_opt_type got, input optld_opt_type exp);
		chk_w({25'h0, got}, {25'h0, exp});
	endtask

	function automatic optld_opt_type dec(input logic [7:0] b);
		return {b[7], b[6], ~b[5], b[4], b[3:2], b[0]};
	endfunction

	task automatic close_out();
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	// Waits for the processor hold to rise and fall, then checks the options.
	task automatic wait_load(input logic [7:0] b);
		int n;
		n = 0;
		while (cpu_reset_hold !== 1'b1 && n < 20) begin
			@(posedge aclk);
			#1;
			n++;
		end
		chk_w(cpu_reset_hold, 1'b1);
		while (cpu_reset_hold !== 1'b0 && n < 300) begin
			@(posedge aclk);
			#1;
			n++;
		end
		chk_w(cpu_reset_hold, 1'b0);
		chk_opt(opt_cfg, dec(b));
	endtask

	task automatic trig(input int src);
		logic [1:0] r;
		r = `OPTLD_RESP_OKAY;
		@(posedge aclk);
		case (src)
			0: sys_reset_req <= 1'b1;
			1: ext_reset_n_pin <= 1'b0;
			2: stop_recovery_pin <= 1'b1;
			3: aresetn <= 1'b0;
			default: axi_wr(`OPTLD_REG_CONTROL, 32'h1, r);
		endcase
		repeat (3) @(posedge aclk);
		#1;
		if (src == 3)
			chk_opt(opt_cfg, `OPTLD_OPT_RST);
		chk_w(r, `OPTLD_RESP_OKAY);
		@(posedge aclk);
		sys_reset_req <= 1'b0;
		ext_reset_n_pin <= 1'b1;
		stop_recovery_pin <= 1'b0;
		aresetn <= 1'b1;
	endtask

	task automatic t_sources();
		logic [7:0] b;
		for (int i = 0; i < 5; i++) begin
			b = {i[0], ~i[0], i[0], ~i[0], i[1:0], 1'b0, ~i[0]};
			user_byte <= b;
			slow <= i[2] | i[0];
			trig(i);
			wait_load(b);
		end
	endtask

	task automatic t_live();
		logic [7:0] b;
		b = user_byte;
		user_byte <= ~b & 8'hFD;
		repeat (30) @(posedge aclk);
		#1;
		chk_opt(opt_cfg, dec(b));
		chk_w(cpu_reset_hold, 1'b0);
		trig(0);
		wait_load(~b & 8'hFD);
	endtask

	task automatic t_gate();
		logic       g;
		logic [7:0] b;
		for (int p = 0; p < 2; p++) begin
			b = 8'hA4 | 8'(p);
			user_byte <= b;
			trig(0);
			wait_load(b);
			for (int k = 0; k < 6; k++) begin
				@(posedge aclk);
				fcmd <= {1'b1, 2'(k >> 1), k[0]};
				@(posedge aclk);
				fcmd.valid <= 1'b0;
				#1;
				g = p[0] | ((k >> 1) == 2 && k[0]);
				chk_w({fcmd_grant, fcmd_deny}, {g, ~g});
			end
		end
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(`OPTLD_REG_STATUS, d, r);
		chk_w(d, 32'h0000_0500);
		chk_w(r, `OPTLD_RESP_OKAY);
		axi_rd(`OPTLD_REG_CONTROL, d, r);
		chk_w(d, 32'h0);
		axi_rd(8'h08, d, r);
		chk_w({d, r}, {32'h0, `OPTLD_RESP_SLVERR});
		axi_wr(8'hFC, 32'h1, r);
		chk_w(r, `OPTLD_RESP_SLVERR);
		repeat (20) @(posedge aclk);
		#1;
		chk_opt(opt_cfg, dec(user_byte));
		chk_w(cpu_reset_hold, 1'b0);
		slow <= 1'b1;
		axi_wr(`OPTLD_REG_CONTROL, 32'h1, r);
		chk_w(r, `OPTLD_RESP_OKAY);
		axi_rd(`OPTLD_REG_STATUS, d, r);
		chk_w(d[1:0], 2'h3);
		wait_load(user_byte);
	endtask

	// Wrongly programmed option bytes still load, and both status flags report them.
	task automatic t_flags();
		logic [31:0] d;
		logic [1:0]  r;
		user_byte <= 8'hA7;
		spare_byte <= 8'hFE;
		trig(0);
		wait_load(8'hA7);
		axi_rd(`OPTLD_REG_STATUS, d, r);
		chk_w(d, 32'h0000_070C);
		chk_w(r, `OPTLD_RESP_OKAY);
	endtask

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		#2000000;
		err_count++;
		close_out();
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		aresetn = 1'b0;
		slow = 1'b0;
		user_byte = 8'hE9;
		spare_byte = 8'hFF;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		sys_reset_req = 1'b0;
		ext_reset_n_pin = 1'b1;
		stop_recovery_pin = 1'b0;
		fcmd = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		wait_load(8'hE9);
		t_sources();
		t_live();
		t_gate();
		t_regs();
		t_flags();
		close_out();
	end
endmodule
